// ==== logic/ctrl_switch_params.svh ====
// constants for the control method switch block
`ifndef CTRL_SWITCH_PARAMS_SVH
`define CTRL_SWITCH_PARAMS_SVH
`define CLK_HZ              10000000
`define CAPTURE_LATENCY_US  2000
`define CAPTURE_CYCLES      ((`CAPTURE_LATENCY_US * (`CLK_HZ / 1000000)))
`define SAMPLE_PERIOD       16'h0064
`define METHOD_INT_SPEED    4'h3
`define METHOD_INT_SPD_SPD  4'h4
`define METHOD_INT_SPD_POS  4'h5
`define METHOD_INT_SPD_TRQ  4'h6
`define METHOD_TRQ_SPD      4'h9
`define METHOD_SPD_ZERO_CLAMP_IN   4'ha
`define METHOD_POS_INHIBIT  4'hb
`define METHOD_RESET        4'h0
`define ALLOC_FACTORY       1'b0
`define ALLOC_ALTERNATE     1'b1
`define SPEED_W             14
`endif

// ==== logic/ctrl_switch_pkg.sv ====
// types for the control method switch block
`default_nettype none
package ctrl_switch_pkg;
   typedef enum logic [2:0] {
      LOOP_INT_SPEED,
      LOOP_SPEED,
      LOOP_POSITION,
      LOOP_TORQUE
   } loop_e;
   typedef struct packed {
      logic fwd_limit_select_in;
      logic rev_limit_select_in;
      logic internal_dir_select_in;
      logic internal_speed_sel_a_in;
      logic internal_speed_sel_b_in;
      logic proportional_ctrl_in;
      logic zero_clamp_in;
      logic pulse_inhibit_in;
      logic ctrl_select_in;
   } inputs_s;
   typedef struct packed {
      loop_e      loop;
      logic       zero_clamp;
      logic       pulse_inhibit;
      logic       reverse;
      logic [1:0] speed_num;
   } select_s;
endpackage
`default_nettype wire

// ==== logic/input_sync.sv ====
// two-flop synchroniser for a group of pin inputs
`default_nettype none
module input_sync #(
   parameter int W = 9
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_r;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_r <= '0;
         o_sync <= '0;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== logic/control_mode_switch_select.sv ====
// decodes the active control method and internal speed from sequence inputs
//
// Behaviour
// (RQ1) forward/reverse speed-select changes acted on within 2 ms.
// (RQ2) capture latency identical whether soft start is active or not.
// (RQ3) leaving internal speed for position decelerates, waits for stop first.
// (RQ4) alternate allocation, methods 4/5/6: select on gives speed/position/torque, off internal.
// (RQ5) speed-select pair: off/off 0, b only 1, both 2, a only 3.
// (RQ6) direction input off forward, on reverse, in internal speed control.
// (RQ7) host assigns control-select and speed/direction terminals explicitly.
// (RQ8) method 9: switch input on speed, off torque.
// (RQ9) factory allocation: proportional input adds zero clamp (A) or inhibit (B).
// (RQ10) alternate allocation: dedicated clamp input in A, inhibit input in B.
// (RQ11) entering internal speed control allowed while motor rotates.
// (RQ12) internal speed setting above motor maximum is limited to maximum.
// (RQ13) method setting takes effect only after restart.
// (RQ14) inputs synchronised; method and speed update together on one edge.
`default_nettype none
`include "ctrl_switch_params.svh"
module control_mode_switch_select
   import ctrl_switch_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_restart,
   input  wire logic [3:0]            i_ctrl_method_setting,
   input  wire logic                  i_input_alloc_mode_setting,
   input  wire logic                  i_fwd_limit_select_in,
   input  wire logic                  i_rev_limit_select_in,
   input  wire logic                  i_internal_dir_select_in,
   input  wire logic                  i_internal_speed_sel_a_in,
   input  wire logic                  i_internal_speed_sel_b_in,
   input  wire logic                  i_proportional_ctrl_in,
   input  wire logic                  i_zero_clamp_in,
   input  wire logic                  i_pulse_inhibit_in,
   input  wire logic                  i_ctrl_select_in,
   input  wire logic                  i_motor_stopped,
   input  wire logic [`SPEED_W-1:0]   i_internal_speed_one,
   input  wire logic [`SPEED_W-1:0]   i_internal_speed_two,
   input  wire logic [`SPEED_W-1:0]   i_internal_speed_three,
   input  wire logic [`SPEED_W-1:0]   i_motor_max_speed,
   output logic      [2:0]            o_loop,
   output logic                       o_zero_clamp,
   output logic                       o_pulse_inhibit,
   output logic                       o_reverse,
   output logic      [1:0]            o_speed_num,
   output logic      [`SPEED_W-1:0]   o_speed_ref,
   output logic                       o_decel_request
);
   inputs_s     pins;
   inputs_s     pins_s;
   select_s     sel_nxt;
   select_s     sel_r;
   logic [3:0]  method_r;
   logic        alloc_r;
   logic [15:0] tick_r;
   logic        sample;
   logic        decel_r;

   assign pins = '{i_fwd_limit_select_in, i_rev_limit_select_in, i_internal_dir_select_in,
                   i_internal_speed_sel_a_in, i_internal_speed_sel_b_in, i_proportional_ctrl_in,
                   i_zero_clamp_in, i_pulse_inhibit_in, i_ctrl_select_in};

   // every pin passes two flops before decode; those cycles count against the latency budget
   input_sync #(.W($bits(inputs_s))) u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (pins),
      .o_sync  (pins_s)
   ); // RQ14

   // settings latched only at restart, reset loads method 0 and factory allocation; live writes are not seen
   // decode reads only these registers, so a setting written mid-run cannot glitch the method
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         method_r <= `METHOD_RESET;
         alloc_r  <= `ALLOC_FACTORY;
      end else if (i_restart) begin
         method_r <= i_ctrl_method_setting; // RQ13
         alloc_r  <= i_input_alloc_mode_setting;
      end
   end

   // fixed 10 us sampling tick, independent of soft start, keeps latency far below 2 ms
   always_ff @(posedge i_clk) begin
      if (i_rst || sample) begin
         tick_r <= '0;
      end else begin
         tick_r <= tick_r + 16'h0001;
      end
   end
   assign sample = (tick_r == `SAMPLE_PERIOD - 16'h0001); // RQ1 RQ2

   // pair runs in gray order, so each one-step change from speed 0 up to speed 3 flips only one pin
   function automatic logic [1:0] speed_code(input logic a, input logic b);
      unique case ({a, b})
         2'b00:   speed_code = 2'h0;
         2'b01:   speed_code = 2'h1;
         2'b11:   speed_code = 2'h2;
         2'b10:   speed_code = 2'h3;
      endcase
   endfunction // RQ5

   function automatic logic [`SPEED_W-1:0] clip(input logic [`SPEED_W-1:0] v,
                                                input logic [`SPEED_W-1:0] mx);
      clip = (v > mx) ? mx : v;
   endfunction // RQ12

   always_comb begin
      logic ssel_a;
      logic ssel_b;
      logic dir;
      logic csel;
      ssel_a = 1'b0;
      ssel_b = 1'b0;
      dir    = 1'b0;
      csel   = 1'b0;
      sel_nxt = '{LOOP_SPEED, 1'b0, 1'b0, 1'b0, 2'h0};
      // terminals come from the explicit alternate assignment, else the factory pins
      if (alloc_r == `ALLOC_ALTERNATE) begin
         ssel_a = pins_s.internal_speed_sel_a_in; // RQ7
         ssel_b = pins_s.internal_speed_sel_b_in;
         dir    = pins_s.internal_dir_select_in;
         csel   = pins_s.ctrl_select_in;
      end else begin
         ssel_a = pins_s.fwd_limit_select_in;
         ssel_b = pins_s.rev_limit_select_in;
         dir    = pins_s.proportional_ctrl_in;
      end
      unique case (method_r)
         `METHOD_INT_SPEED: begin
            sel_nxt.loop = LOOP_INT_SPEED;
         end
         `METHOD_INT_SPD_SPD, `METHOD_INT_SPD_POS, `METHOD_INT_SPD_TRQ: begin
            if (alloc_r == `ALLOC_ALTERNATE) begin
               csel = pins_s.ctrl_select_in;
            end else begin
               // factory pins: both speed selects off hands over to the external method,
               // any other pair keeps internal speed, so no separate select pin is needed
               csel = (speed_code(ssel_a, ssel_b) == 2'h0);
            end
            if (!csel) begin
               sel_nxt.loop = LOOP_INT_SPEED; // RQ4 RQ11
            end else if (method_r == `METHOD_INT_SPD_SPD) begin
               sel_nxt.loop = LOOP_SPEED; // RQ4
            end else if (method_r == `METHOD_INT_SPD_POS) begin
               sel_nxt.loop = LOOP_POSITION;
            end else begin
               sel_nxt.loop = LOOP_TORQUE;
            end
         end
         `METHOD_TRQ_SPD: begin
            csel = (alloc_r == `ALLOC_ALTERNATE) ? pins_s.ctrl_select_in : pins_s.proportional_ctrl_in;
            sel_nxt.loop = csel ? LOOP_SPEED : LOOP_TORQUE; // RQ8
         end
         `METHOD_SPD_ZERO_CLAMP_IN: begin
            sel_nxt.loop = LOOP_SPEED;
            sel_nxt.zero_clamp = (alloc_r == `ALLOC_ALTERNATE) ? pins_s.zero_clamp_in
                                                               : pins_s.proportional_ctrl_in; // RQ9 RQ10
         end
         `METHOD_POS_INHIBIT: begin
            sel_nxt.loop = LOOP_POSITION;
            sel_nxt.pulse_inhibit = (alloc_r == `ALLOC_ALTERNATE) ? pins_s.pulse_inhibit_in
                                                                  : pins_s.proportional_ctrl_in; // RQ9 RQ10
         end
         default: begin
            // unused method codes fall back to plain speed control
            sel_nxt.loop = LOOP_SPEED;
         end
      endcase
      if (sel_nxt.loop == LOOP_INT_SPEED) begin
         sel_nxt.speed_num = speed_code(ssel_a, ssel_b); // RQ5
         sel_nxt.reverse   = dir; // RQ6
      end
   end

   // selection moves on one sample edge, whole except while waiting for stop (then only speed_num), so method and speed never mix
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sel_r   <= '{LOOP_SPEED, 1'b0, 1'b0, 1'b0, 2'h0};
         decel_r <= 1'b0;
      end else if (sample) begin
         if (sel_r.loop == LOOP_INT_SPEED && sel_nxt.loop == LOOP_POSITION && !i_motor_stopped) begin
            // hold internal speed, command stop ramp until motor halts
            // the ramp itself lives in the speed loop and follows the soft start deceleration
            // time; this block only asks for it and waits for standstill
            sel_r.speed_num <= 2'h0; // RQ3
            decel_r         <= 1'b1;
         end else begin
            sel_r   <= sel_nxt; // RQ14
            decel_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_loop          <= 3'h1;
         o_zero_clamp    <= 1'b0;
         o_pulse_inhibit <= 1'b0;
         o_reverse       <= 1'b0;
         o_speed_num     <= 2'h0;
         o_speed_ref     <= '0;
         o_decel_request <= 1'b0;
      end else begin
         o_loop          <= sel_r.loop;
         o_zero_clamp    <= sel_r.zero_clamp;
         o_pulse_inhibit <= sel_r.pulse_inhibit;
         o_reverse       <= sel_r.reverse;
         o_speed_num     <= sel_r.speed_num;
         o_decel_request <= decel_r; // RQ3
         // clipped every cycle because the speed settings may be rewritten at any time
         unique case (sel_r.speed_num)
            2'h0: o_speed_ref <= '0;
            2'h1: o_speed_ref <= clip(i_internal_speed_one, i_motor_max_speed);
            2'h2: o_speed_ref <= clip(i_internal_speed_two, i_motor_max_speed);
            2'h3: o_speed_ref <= clip(i_internal_speed_three, i_motor_max_speed);
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== verif/ctrl_switch_assertions.sv ====
// checker on the control method switch outputs
`default_nettype none
`include "ctrl_switch_params.svh"
module ctrl_switch_assertions (
   input wire logic                i_clk,
   input wire logic                i_rst,
   input wire logic [`SPEED_W-1:0] i_motor_max_speed,
   input wire logic [2:0]          o_loop,
   input wire logic                o_zero_clamp,
   input wire logic                o_pulse_inhibit,
   input wire logic                o_reverse,
   input wire logic [1:0]          o_speed_num,
   input wire logic [`SPEED_W-1:0] o_speed_ref,
   input wire logic                o_decel_request
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic [6:0] sel = {o_loop, o_speed_num, o_zero_clamp, o_pulse_inhibit};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_reset_state: assert property (disable iff (1'b0) i_rst |=> o_loop == 3'h1 && o_speed_num == 2'h0
      && !o_zero_clamp && !o_pulse_inhibit && !o_reverse && !o_decel_request) else $error("bad reset state");
   a_speed_clip: assert property (o_speed_ref <= i_motor_max_speed) else $error("speed above max");
   a_stop_zero: assert property (o_speed_num == 2'h0 |-> o_speed_ref == '0) else $error("stop not zero");
   a_decel_int: assert property (o_decel_request |-> o_loop == 3'h0 && o_speed_num == 2'h0)
      else $error("decel outside internal speed");
   a_clamp_speed: assert property (o_zero_clamp |-> o_loop == 3'h1) else $error("clamp outside speed");
   a_inhibit_pos: assert property (o_pulse_inhibit |-> o_loop == 3'h2) else $error("inhibit off position");
   a_ext_no_speed: assert property (o_loop != 3'h0 |-> o_speed_num == 2'h0) else $error("speed num leaked");
   a_update_once: assert property ($changed(sel) |=> $stable(sel) [*8])
      else $error("selection moved twice");
endmodule
bind control_mode_switch_select ctrl_switch_assertions chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_motor_max_speed(i_motor_max_speed), .o_loop(o_loop), .o_zero_clamp(o_zero_clamp),
   .o_pulse_inhibit(o_pulse_inhibit), .o_reverse(o_reverse), .o_speed_num(o_speed_num),
   .o_speed_ref(o_speed_ref), .o_decel_request(o_decel_request));
`default_nettype wire

// ==== verif/host_pins.sv ====
// host controller model driving the discrete sequence pins
`default_nettype none
module host_pins
   import ctrl_switch_pkg::*;
(
   input  wire inputs_s i_req,
   output var  inputs_s o_pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // every function has its own explicitly assigned terminal
   assign o_pins = i_req;
endmodule
`default_nettype wire

// ==== verif/control_mode_switch_select_test.sv ====
// testbench for the control method switch
`default_nettype none
module control_mode_switch_select_test
   import ctrl_switch_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst, restart, alloc, stopped;
   logic [3:0]  method;
   logic [13:0] sp1, sp2, sp3, mx, o_ref;
   inputs_s     req, pins;
   logic [2:0]  o_loop;
   logic [1:0]  o_num;
   logic        o_zc, o_pi, o_rev, o_dc;
   int          errors = 0;
   int          check_count = 0;
   always #50 clk = ~clk;
   host_pins host (.i_req(req), .o_pins(pins));
   control_mode_switch_select DUT (.i_clk(clk), .i_rst(rst), .i_restart(restart),
      .i_ctrl_method_setting(method), .i_input_alloc_mode_setting(alloc),
      .i_fwd_limit_select_in(pins.fwd_limit_select_in), .i_rev_limit_select_in(pins.rev_limit_select_in),
      .i_internal_dir_select_in(pins.internal_dir_select_in),
      .i_internal_speed_sel_a_in(pins.internal_speed_sel_a_in),
      .i_internal_speed_sel_b_in(pins.internal_speed_sel_b_in),
      .i_proportional_ctrl_in(pins.proportional_ctrl_in), .i_zero_clamp_in(pins.zero_clamp_in),
      .i_pulse_inhibit_in(pins.pulse_inhibit_in), .i_ctrl_select_in(pins.ctrl_select_in),
      .i_motor_stopped(stopped), .i_internal_speed_one(sp1), .i_internal_speed_two(sp2),
      .i_internal_speed_three(sp3), .i_motor_max_speed(mx), .o_loop(o_loop), .o_zero_clamp(o_zc),
      .o_pulse_inhibit(o_pi), .o_reverse(o_rev), .o_speed_num(o_num), .o_speed_ref(o_ref),
      .o_decel_request(o_dc));
   task automatic finish_test;
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic restart_with(input logic [3:0] m, input logic a);
      @(negedge clk);
      method = m;
      alloc = a;
      restart = 1'b1;
      @(negedge clk);
      restart = 1'b0;
   endtask
   // waits past sync plus one full sample period, far inside the 2 ms budget
   task automatic check_sel(input logic [2:0] lp, input logic [1:0] num, input logic rv, zc, pi, dc);
      logic [13:0] rf;
      rf = num == 2'h1 ? sp1 : num == 2'h2 ? sp2 : num == 2'h3 ? (sp3 > mx ? mx : sp3) : 14'h0000;
      repeat (120) @(negedge clk);
      check_count++;
      if ({o_loop, o_num, o_rev, o_zc, o_pi, o_dc, o_ref} !== {lp, num, rv, zc, pi, dc, rf}) begin
         errors++;
         $display("MISMATCH %0t loop %0d num %0d ref %0d", $time, o_loop, o_num, o_ref);
      end
   endtask
   initial begin
      #2000000;
      errors++;
      finish_test;
   end
   initial begin
      rst = 1'b1; restart = 1'b0; method = 4'h0; alloc = 1'b0; stopped = 1'b1; req = '0;
      sp1 = 14'h0064; sp2 = 14'h00c8; sp3 = 14'h012c; mx = 14'h00fa;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      check_sel(3'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      for (int m = 4; m <= 6; m++) begin
         restart_with(m[3:0], 1'b1);
         req.ctrl_select_in = 1'b1;
         check_sel(m[2:0] - 3'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
         req.ctrl_select_in = 1'b0;
         for (int c = 0; c < 8; c++) begin
            {req.internal_dir_select_in, req.internal_speed_sel_a_in, req.internal_speed_sel_b_in} = c[2:0] ^ 3'h4;
            check_sel(3'h0, {c[1], c[1] ^ c[0]}, !c[2], 1'b0, 1'b0, 1'b0);
         end
         if (m == 5) begin
            stopped = 1'b0;
            req.ctrl_select_in = 1'b1;
            check_sel(3'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
            stopped = 1'b1;
            check_sel(3'h2, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
         end
      end
      // live write without restart: decode must stay at internal speed 2, forward
      method = 4'h9;
      check_sel(3'h0, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0);
      for (int a = 0; a < 2; a++) begin
         restart_with(4'h9, a[0]);
         req = '0;
         {req.proportional_ctrl_in, req.ctrl_select_in} = a[0] ? 2'b01 : 2'b10;
         check_sel(3'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
         req = '0;
         check_sel(3'h3, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         restart_with(k[0] ? 4'hb : 4'ha, k[1]);
         req.proportional_ctrl_in = !k[1];
         req.zero_clamp_in = k[1];
         req.pulse_inhibit_in = k[1];
         check_sel(k[0] ? 3'h2 : 3'h1, 2'h0, 1'b0, !k[0], k[0], 1'b0);
         req = '0;
         check_sel(k[0] ? 3'h2 : 3'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      end
      stopped = 1'b0;
      restart_with(4'h4, 1'b0);
      req.rev_limit_select_in = 1'b1;
      req.proportional_ctrl_in = 1'b1;
      check_sel(3'h0, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0);
      req = '0;
      check_sel(3'h1, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      finish_test;
   end
endmodule
`default_nettype wire
